// ---- rtl/rre_params.svh ----
// constants for the rotate-right execution block
`ifndef RRE_PARAMS_SVH
`define RRE_PARAMS_SVH
`define RRE_OPC_POS 10
`define RRE_OPC_VIA_CARRY 6'h0C
`define RRE_OPC_WRAP 6'h10
`define RRE_DEST_POS 9
`define RRE_ACCESS_POS 8
`define RRE_LITERAL_MAX 8'h5F
`define RRE_ACC_RESET 8'h00
`define RRE_FLAG_RESET 1'h0
`define RRE_BANK_RESET 6'h00
`endif

// ---- rtl/rre_pkg.sv ----
// types for the rotate-right execution block
package rre_pkg;
  typedef enum logic [1:0] {
    RRE_Q1,
    RRE_Q2,
    RRE_Q3,
    RRE_Q4
  } rre_phase_t;
  typedef enum logic [1:0] {
    RRE_ADDR_ACCESS,
    RRE_ADDR_BANKED,
    RRE_ADDR_INDEXED
  } rre_addr_mode_t;
endpackage

// ---- rtl/rre_rot_if.sv ----
// operand and result carrier between control and rotate unit
`timescale 1ns/10ps
interface rre_rot_if;
  logic [7:0] operand;
  logic carry;
  logic wrap;
  logic [7:0] result;
  logic next_carry;
  logic neg;
  logic zero;
  modport ctrl (output operand, output carry, output wrap,
    input result, input next_carry, input neg, input zero);
  modport unit (input operand, input carry, input wrap,
    output result, output next_carry, output neg, output zero);
endinterface

// ---- rtl/rre_rotate_unit.sv ----
// combinational rotate-right core
`timescale 1ns/10ps
module rre_rotate_unit (
  rre_rot_if.unit rot
);
  always_comb begin
    if (rot.wrap) begin
      rot.result = {rot.operand[0], rot.operand[7:1]};
      rot.next_carry = rot.carry;
    end else begin
      rot.result = {rot.carry, rot.operand[7:1]};
      rot.next_carry = rot.operand[0];
    end
    rot.neg = rot.result[7];
    rot.zero = (rot.result == 8'h00);
  end
endmodule

// ---- rtl/rre_exec.sv ----
// rotate-right instruction execution datapath
// Functional notes
// - via-carry rotate: bit 0 to carry, old carry into bit 7
// - destination bit 0 writes accumulator, 1 writes file register back
// - access bit 0 addresses access bank, bank select ignored
// - access bit 1 uses bank select register for the bank
// - access 0, extended set, address up to 5Fh: indexed literal offset
// - wraparound rotate: bit 0 into bit 7, only negative and zero change
`timescale 1ns/10ps
`include "rre_params.svh"
module rre_exec
  import rre_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_word_in,
  input wire logic extended_set_in,
  input wire logic [5:0] bank_select_register_in,
  input wire logic [7:0] indexed_base_in,
  input wire logic [7:0] file_rdata_in,
  output logic instr_ready_out,
  output logic illegal_out,
  output logic file_rd_out,
  output logic [13:0] file_addr_out,
  output logic file_wr_out,
  output logic [7:0] file_wdata_out,
  output logic [7:0] accumulator_out,
  output logic carry_out,
  output logic negative_out,
  output logic zero_out,
  output logic [1:0] addr_mode_out,
  output logic done_out
);
  rre_phase_t phase;
  logic busy;
  logic [15:0] instr;
  logic [7:0] operand;
  logic [7:0] result;
  logic res_carry;
  logic res_neg;
  logic res_zero;
  logic [5:0] opc;
  logic [7:0] faddr;
  logic is_via_carry;
  logic is_wrap;
  rre_addr_mode_t next_mode;
  logic [13:0] next_addr;
  logic [7:0] idx_sum;
  logic is_rotate;
  logic take;
  logic last_phase;
  rre_rot_if rot ();
  rre_rotate_unit u_rot (
    .rot(rot)
  );
  assign opc = instr_word_in[15:`RRE_OPC_POS];
  assign faddr = instr_word_in[7:0];
  assign is_via_carry = (opc == `RRE_OPC_VIA_CARRY);
  assign is_wrap = (opc == `RRE_OPC_WRAP);
  assign idx_sum = indexed_base_in + faddr;
  // operand address selection
  always_comb begin
    if (instr_word_in[`RRE_ACCESS_POS]) begin
      next_mode = RRE_ADDR_BANKED;
      next_addr = {bank_select_register_in, faddr};
    end else if (extended_set_in && faddr <= `RRE_LITERAL_MAX) begin
      next_mode = RRE_ADDR_INDEXED;
      next_addr = {6'h00, idx_sum};
    end else if (faddr <= `RRE_LITERAL_MAX) begin
      next_mode = RRE_ADDR_ACCESS;
      next_addr = {6'h00, faddr};
    end else begin
      next_mode = RRE_ADDR_ACCESS;
      next_addr = {6'h3F, faddr};
    end
  end
  assign rot.operand = operand;
  assign rot.carry = carry_out;
  assign rot.wrap = instr[`RRE_OPC_POS + 4];
  // instruction accepted this edge
  assign is_rotate = is_via_carry || is_wrap;
  assign take = !busy && instr_valid_in && is_rotate;
  assign last_phase = busy && (phase == RRE_Q4);
  // busy over the second to fourth quarters
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      busy <= 1'b0;
    end else if (take) begin
      busy <= 1'b1;
    end else if (last_phase) begin
      busy <= 1'b0;
    end
  end
  // quarter-phase sequencing
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      phase <= RRE_Q1;
    end else if (take) begin
      phase <= RRE_Q2;
    end else if (busy) begin
      unique case (phase)
        RRE_Q1: begin
          phase <= RRE_Q2;
        end
        RRE_Q2: begin
          phase <= RRE_Q3;
        end
        RRE_Q3: begin
          phase <= RRE_Q4;
        end
        RRE_Q4: begin
          phase <= RRE_Q1;
        end
      endcase
    end
  end
  // decoded instruction capture
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      instr <= 16'h0000;
    end else if (take) begin
      instr <= instr_word_in;
    end
  end
  // operand address and mode
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      file_addr_out <= 14'h0000;
      addr_mode_out <= 2'h0;
    end else if (take) begin
      file_addr_out <= next_addr;
      addr_mode_out <= next_mode;
    end
  end
  // one-cycle read strobe
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      file_rd_out <= 1'b0;
    end else begin
      file_rd_out <= take;
    end
  end
  // non-rotate word offered while idle
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      illegal_out <= 1'b0;
    end else if (!busy && instr_valid_in) begin
      illegal_out <= !is_rotate;
    end
  end
  // read register in the second quarter
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      operand <= 8'h00;
    end else if (busy && phase == RRE_Q2) begin
      operand <= file_rdata_in;
    end
  end
  // process data in the third quarter
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      result <= 8'h00;
      res_carry <= `RRE_FLAG_RESET;
      res_neg <= `RRE_FLAG_RESET;
      res_zero <= `RRE_FLAG_RESET;
    end else if (busy && phase == RRE_Q3) begin
      result <= rot.result;
      res_carry <= rot.next_carry;
      res_neg <= rot.neg;
      res_zero <= rot.zero;
    end
  end
  // status flags in the fourth quarter
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      carry_out <= `RRE_FLAG_RESET;
      negative_out <= `RRE_FLAG_RESET;
      zero_out <= `RRE_FLAG_RESET;
    end else if (last_phase) begin
      carry_out <= res_carry;
      negative_out <= res_neg;
      zero_out <= res_zero;
    end
  end
  // accumulator destination
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      accumulator_out <= `RRE_ACC_RESET;
    end else if (last_phase && !instr[`RRE_DEST_POS]) begin
      accumulator_out <= result;
    end
  end
  // file register write-back
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      file_wr_out <= 1'b0;
      file_wdata_out <= 8'h00;
    end else begin
      file_wr_out <= last_phase && instr[`RRE_DEST_POS];
      if (last_phase && instr[`RRE_DEST_POS]) begin
        file_wdata_out <= result;
      end
    end
  end
  // completion pulse
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= last_phase;
    end
  end
  // ready when idle or finishing
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      instr_ready_out <= 1'b0;
    end else begin
      instr_ready_out <= (!busy && !take) || last_phase;
    end
  end
endmodule

// ---- verif/rre_exec_asserts.sv ----
// assertion checker for the rotate-right execution block
`timescale 1ns/10ps
module rre_exec_asserts (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [15:0] instr_word_in,
  input wire logic extended_set_in,
  input wire logic [5:0] bank_select_register_in,
  input wire logic [7:0] file_rdata_in,
  input wire logic file_rd_out,
  input wire logic [13:0] file_addr_out,
  input wire logic file_wr_out,
  input wire logic [7:0] accumulator_out,
  input wire logic carry_out,
  input wire logic [1:0] addr_mode_out,
  input wire logic done_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  logic [15:0] w;
  logic x;
  always_ff @(posedge clk_in) begin
    w <= instr_word_in;
    x <= extended_set_in;
  end
  a_read_to_done: assert property (
    file_rd_out |-> ##3 done_out) else $error("no done");
  a_dest_select: assert property (
    done_out |-> file_wr_out == $past(w[9], 3)) else $error("dest");
  a_acc_update: assert property (
    $changed(accumulator_out) && !$past(srst_in) |->
    done_out && !file_wr_out)
    else $error("acc");
  a_access_bank: assert property (
    file_rd_out && !w[8] && !x |-> addr_mode_out == 2'h0
    && file_addr_out[7:0] == w[7:0]) else $error("access");
  a_banked_addr: assert property (
    file_rd_out && w[8] |-> file_addr_out ==
    {$past(bank_select_register_in), w[7:0]}) else $error("bank");
  a_indexed_mode: assert property (
    file_rd_out && !w[8] && x |->
    (addr_mode_out == 2'h2) == (w[7:0] <= 8'h5F)) else $error("index");
  a_carry_bit0: assert property (
    done_out && $past(w[15:10], 3) == 6'h0C |->
    carry_out == $past(file_rdata_in[0], 3)) else $error("carry");
  a_wrap_carry: assert property (
    done_out && $past(w[15:10], 3) == 6'h10 |-> $stable(carry_out))
    else $error("wrap");
  c_carry: cover property (done_out && carry_out);
  c_indexed: cover property (file_rd_out && addr_mode_out == 2'h2);
  c_acc: cover property (done_out && !file_wr_out);
endmodule
bind rre_exec rre_exec_asserts checker_inst (
  .clk_in(clk_in),
  .srst_in(srst_in),
  .instr_word_in(instr_word_in),
  .extended_set_in(extended_set_in),
  .bank_select_register_in(bank_select_register_in),
  .file_rdata_in(file_rdata_in),
  .file_rd_out(file_rd_out),
  .file_addr_out(file_addr_out),
  .file_wr_out(file_wr_out),
  .accumulator_out(accumulator_out),
  .carry_out(carry_out),
  .addr_mode_out(addr_mode_out),
  .done_out(done_out)
);

// ---- verif/test_rotate_right_execution.sv ----
// testbench for the rotate-right execution block
`timescale 1ns/10ps
module test_rotate_right_execution;
  logic clk_in, srst_in, instr_valid_in, extended_set_in, c_exp;
  logic instr_ready_out, illegal_out, file_rd_out, file_wr_out;
  logic carry_out, negative_out, zero_out, done_out;
  logic [15:0] instr_word_in;
  logic [13:0] file_addr_out;
  logic [7:0] indexed_base_in, file_rdata_in, file_wdata_out;
  logic [7:0] accumulator_out, acc_exp;
  logic [5:0] bank_select_register_in;
  logic [1:0] addr_mode_out;
  int bad_count = 0;
  int checked = 0;
  rre_exec dut (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .instr_valid_in(instr_valid_in),
    .instr_word_in(instr_word_in),
    .extended_set_in(extended_set_in),
    .bank_select_register_in(bank_select_register_in),
    .indexed_base_in(indexed_base_in),
    .file_rdata_in(file_rdata_in),
    .instr_ready_out(instr_ready_out),
    .illegal_out(illegal_out),
    .file_rd_out(file_rd_out),
    .file_addr_out(file_addr_out),
    .file_wr_out(file_wr_out),
    .file_wdata_out(file_wdata_out),
    .accumulator_out(accumulator_out),
    .carry_out(carry_out),
    .negative_out(negative_out),
    .zero_out(zero_out),
    .addr_mode_out(addr_mode_out),
    .done_out(done_out)
  );
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic offer(input logic [15:0] w, input logic [7:0] rd,
    input logic ext);
    @(negedge clk_in);
    repeat (9) if (instr_ready_out !== 1'h1) @(negedge clk_in);
    @(posedge clk_in);
    instr_valid_in <= 1'h1;
    instr_word_in <= w;
    file_rdata_in <= rd;
    extended_set_in <= ext;
    @(posedge clk_in);
    instr_valid_in <= 1'h0;
  endtask
  task automatic rot(input logic [15:0] w, input logic [7:0] rd,
    input logic ext);
    logic [7:0] r;
    logic [13:0] a;
    logic [1:0] m;
    r = {w[14] ? rd[0] : c_exp, rd[7:1]};
    if (!w[14]) c_exp = rd[0];
    if (!w[9]) acc_exp = r;
    m = w[8] ? 2'h1 : (ext && w[7:0] <= 8'h5F) ? 2'h2 : 2'h0;
    a = {w[7:0] > 8'h5F ? 6'h3F : 6'h00, w[7:0]};
    if (w[8]) a = {6'h15, w[7:0]};
    if (m == 2'h2) a = {6'h00, w[7:0] + 8'h20};
    offer(w, rd, ext);
    @(negedge clk_in);
    chk({file_rd_out, instr_ready_out}, 2'h2);
    chk({addr_mode_out, file_addr_out}, {m, a});
    repeat (3) @(negedge clk_in);
    chk({done_out, instr_ready_out, file_wr_out}, {2'h3, w[9]});
    chk(accumulator_out, acc_exp);
    chk(carry_out, c_exp);
    chk({negative_out, zero_out}, {r[7], r == 8'h00});
    if (w[9]) chk(file_wdata_out, r);
  endtask
  initial begin
    clk_in = 1'h0;
    forever #2 clk_in = ~clk_in;
  end
  initial begin
    #2000;
    bad_count++;
    close_out();
  end
  initial begin
    srst_in = 1'h1;
    {instr_valid_in, extended_set_in, c_exp} = 3'h0;
    {instr_word_in, file_rdata_in, acc_exp} = 32'h0;
    bank_select_register_in = 6'h15;
    indexed_base_in = 8'h20;
    repeat (3) @(posedge clk_in);
    srst_in <= 1'h0;
    offer(16'hFFFF, 8'h00, 1'h0);
    repeat (2) @(negedge clk_in);
    chk({illegal_out, file_rd_out}, 2'h2);
    rot(16'h3010, 8'hE6, 1'h0);
    rot(16'h4210, 8'hD7, 1'h0);
    rot(16'h3380, 8'h01, 1'h0);
    rot(16'h305F, 8'h00, 1'h1);
    rot(16'h4060, 8'h02, 1'h1);
    rot(16'h435F, 8'h81, 1'h1);
    @(posedge clk_in);
    srst_in <= 1'h1;
    @(posedge clk_in);
    srst_in <= 1'h0;
    c_exp = 1'h0;
    acc_exp = 8'h00;
    @(negedge clk_in);
    chk({accumulator_out, negative_out, instr_ready_out}, 10'h000);
    rot(16'h3001, 8'h03, 1'h0);
    close_out();
  end
endmodule
